// ===== fco_pkg.sv
// What this block does
// - Ratio-loaded flag: reset clears, first write sets
// - Low seven ratio bits accept one write
// - Program/erase refused until ratio loaded
// - Prescale bit selects bus clock divided by eight
// - Timing clock equals input over ratio plus one
// - Timing pulse lasts one bus clock cycle unless ratio is zero with prescale off
// - Option byte copied into option register at reset
// - Option bits five to two read zero
// - Bus writes to option register ignored
// - Key disabled means no backdoor unlock
// - Key enable and data writes accepted only from secure firmware; closing write from any source
// - Matching ordered eight-byte key unsecures until reset
// - Remap-off bit disables vector redirection
// - Only code 1:0 means unsecured
// - Secure state blocks unsecured memory accesses
// - Key match or passing blank check sets code 1:0
// - Six byte registers, one loaded at reset
// - Blocked write ignored, blocked read returns zero
// - Early program/erase sets access error, ignored
package fco_pkg;
    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [3:0] FCO_ADDR_RATIO = 4'h0;
    localparam logic [3:0] FCO_ADDR_OPTS = 4'h1;
    localparam logic [3:0] FCO_ADDR_KEYCTL = 4'h2;
    localparam logic [3:0] FCO_ADDR_STATUS = 4'h3;
    localparam logic [3:0] FCO_ADDR_KEYDATA = 4'h4;
    localparam logic [3:0] FCO_ADDR_CMD = 4'h5;
    // ----------------------------------------
    // Fields and reset values
    // ----------------------------------------
    localparam int FCO_LOADED_BIT = 7;
    localparam int FCO_PRESCALE_BIT = 6;
    localparam int FCO_RATIO_W = 6;
    localparam int FCO_BACKDOOR_KEY_ALLOW_BIT = 7;
    localparam int FCO_REMAP_OFF_BIT = 6;
    localparam int FCO_KEY_BYTES = 8;
    localparam int FCO_PRESCALE_DIV = 8;
    localparam logic [6:0] FCO_RATIO_RST = 7'h00;
    localparam logic [1:0] FCO_SEC_OPEN = 2'h2;
    localparam logic [7:0] FCO_OPTS_MASK = 8'hC3;
    localparam int FCO_ERR_BIT = 4;
    localparam int FCO_BLANK_BIT = 2;
    localparam logic [7:0] FCO_CMD_BLANK = 8'h05;
    localparam logic [7:0] FCO_CMD_PROG = 8'h20;
    localparam logic [7:0] FCO_CMD_BURST = 8'h25;
    localparam logic [7:0] FCO_CMD_PAGE_ERASE = 8'h40;
    localparam logic [7:0] FCO_CMD_MASS_ERASE = 8'h41;
    localparam int FCO_PULSE_CYC = 1;
endpackage

// ===== fco_tick_if.sv
`timescale 1ns/1ns
`default_nettype none
interface fco_tick_if;
    logic load;
    logic prescale;
    logic [5:0] ratio;
    logic tick;
    modport src (input load, input prescale, input ratio, output tick);
    modport user (output load, output prescale, output ratio, input tick);
endinterface
`default_nettype wire

// ===== fco_tick_gen.sv
`timescale 1ns/1ns
`default_nettype none
module fco_tick_gen
    import fco_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_resetn,
    fco_tick_if.src t
);
    logic [2:0] pre_ff;
    logic [5:0] cnt_ff;
    logic tick_ff;
    wire pre_hit = (pre_ff == 3'(FCO_PRESCALE_DIV - 1));
    wire div_in = t.prescale ? pre_hit : 1'b1;
    wire cnt_hit = (cnt_ff == 6'h00);
    always_ff @(posedge i_mclk) begin
        if (!i_resetn || !t.load) begin
            pre_ff <= 3'h0;
            cnt_ff <= 6'h00;
            tick_ff <= 1'b0;
        end else begin
            pre_ff <= pre_hit ? 3'h0 : pre_ff + 3'h1;
            tick_ff <= div_in && cnt_hit;
            if (div_in) begin
                cnt_ff <= cnt_hit ? t.ratio : cnt_ff - 6'h01;
            end
        end
    end
    assign t.tick = tick_ff;
endmodule // fco_tick_gen
`default_nettype wire

// ===== fco_flash_opts.sv
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module fco_flash_opts
    import fco_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_secure_src,
    input wire logic i_mem_req,
    input wire logic i_mem_wr,
    input wire logic [7:0] i_mem_rdata,
    input wire logic [7:0] i_stored_option_byte,
    input wire logic [63:0] i_stored_unlock_key,
    input wire logic i_blank_done,
    input wire logic i_blank_ok,
    output logic [7:0] o_rdata,
    output logic [7:0] o_mem_rdata,
    output logic o_mem_wr_en,
    output logic o_nvm_timing_clock,
    output logic o_cmd_start,
    output logic [7:0] o_cmd_code,
    output logic o_vector_remap_off,
    output logic o_secure
);
    import fco_pkg::*;
    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef enum logic [1:0] {
        FCO_K_IDLE = 2'b00,
        FCO_K_COLLECT = 2'b01,
        FCO_K_FAIL = 2'b10
    } fco_key_t;
    fco_key_t key_st_ff;
    logic ratio_loaded_flag_ff;
    logic [6:0] ratio_ff;
    logic [7:0] opts_ff;
    logic opts_taken_ff;
    logic [1:0] security_code_ff;
    logic access_error_flag_ff;
    logic blank_ff;
    logic [3:0] key_idx_ff;
    logic key_acc_ff;
    logic [7:0] rdata_ff;
    logic [7:0] mem_rdata_ff;
    logic mem_wr_en_ff;
    logic cmd_start_ff;
    logic [7:0] cmd_code_ff;
    logic remap_ff;
    logic secure_ff;
    logic [7:0] key_bytes [FCO_KEY_BYTES];
    // ----------------------------------------
    // Decode
    // ----------------------------------------
    wire wr_ratio = i_wr && (i_addr == FCO_ADDR_RATIO);
    wire wr_keyctl = i_wr && (i_addr == FCO_ADDR_KEYCTL);
    wire wr_status = i_wr && (i_addr == FCO_ADDR_STATUS);
    wire wr_keydata = i_wr && (i_addr == FCO_ADDR_KEYDATA);
    wire wr_cmd = i_wr && (i_addr == FCO_ADDR_CMD);
    wire is_secure = (security_code_ff != FCO_SEC_OPEN);
    wire is_pe = (i_wdata == FCO_CMD_PROG) || (i_wdata == FCO_CMD_BURST) ||
        (i_wdata == FCO_CMD_PAGE_ERASE) || (i_wdata == FCO_CMD_MASS_ERASE);
    wire pe_refused = wr_cmd && is_pe && !ratio_loaded_flag_ff;
    wire cmd_go = wr_cmd && !pe_refused;
    wire key_allowed = opts_ff[FCO_BACKDOOR_KEY_ALLOW_BIT] && i_secure_src;
    wire key_byte_ok = (key_idx_ff < 4'(FCO_KEY_BYTES)) &&
        (i_wdata == key_bytes[key_idx_ff[2:0]]);
    wire key_finish = wr_keyctl && key_acc_ff && !i_wdata[5];
    wire key_match = key_finish && (key_st_ff == FCO_K_COLLECT) &&
        (key_idx_ff == 4'(FCO_KEY_BYTES));
    wire mem_block = i_mem_req && is_secure && !i_secure_src;
    wire [7:0] ratio_rd = {ratio_loaded_flag_ff, ratio_ff};
    // The security bits read back the working code, so an unlock shows up here.
    wire [7:0] opts_rd = {opts_ff[7:2], security_code_ff} & FCO_OPTS_MASK;
    wire [7:0] status_rd = {3'h0, access_error_flag_ff, 1'b0, blank_ff, 2'h0};
    wire [7:0] rd_mux = (i_addr == FCO_ADDR_RATIO) ? ratio_rd :
        (i_addr == FCO_ADDR_OPTS) ? opts_rd :
        (i_addr == FCO_ADDR_KEYCTL) ? {2'h0, key_acc_ff, 5'h00} :
        (i_addr == FCO_ADDR_STATUS) ? status_rd : 8'h00;
    // ----------------------------------------
    // Stored key split into bytes
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < FCO_KEY_BYTES; g++) begin : g_key
            assign key_bytes[g] = i_stored_unlock_key[8*g +: 8];
        end
    endgenerate
    // ----------------------------------------
    // Timing strobe
    // ----------------------------------------
    fco_tick_if tk();
    assign tk.load = ratio_loaded_flag_ff;
    assign tk.prescale = ratio_ff[FCO_PRESCALE_BIT];
    assign tk.ratio = ratio_ff[FCO_RATIO_W-1:0];
    fco_tick_gen u_tick (
        .i_mclk(i_mclk),
        .i_resetn(i_resetn),
        .t(tk.src)
    );
    // ----------------------------------------
    // Divider register
    // ----------------------------------------
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            ratio_loaded_flag_ff <= 1'b0;
            ratio_ff <= FCO_RATIO_RST;
        end else if (wr_ratio && !ratio_loaded_flag_ff) begin
            ratio_loaded_flag_ff <= 1'b1;
            ratio_ff <= i_wdata[6:0];
        end
    end
    // ----------------------------------------
    // Option register, loaded during reset
    // ----------------------------------------
    // The option byte is sampled while reset is held, so a stored value
    // that settles late in reset is still caught; bus writes never land.
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            opts_ff <= i_stored_option_byte;
            opts_taken_ff <= 1'b0;
        end else begin
            opts_taken_ff <= 1'b1;
        end
    end
    // ----------------------------------------
    // Security state
    // ----------------------------------------
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            security_code_ff <= i_stored_option_byte[1:0];
        end else if (key_match || (i_blank_done && i_blank_ok)) begin
            security_code_ff <= FCO_SEC_OPEN;
        end
    end
    // ----------------------------------------
    // Key sequencer
    // ----------------------------------------
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            key_acc_ff <= 1'b0;
            key_st_ff <= FCO_K_IDLE;
            key_idx_ff <= 4'h0;
        end else if (wr_keyctl && i_secure_src) begin
            key_acc_ff <= i_wdata[5];
            key_st_ff <= i_wdata[5] ? FCO_K_COLLECT : FCO_K_IDLE;
            key_idx_ff <= 4'h0;
        end else if (wr_keydata && key_acc_ff) begin
            case (key_st_ff)
                FCO_K_COLLECT: begin
                    if (key_allowed && key_byte_ok) begin
                        key_idx_ff <= key_idx_ff + 4'h1;
                    end else begin
                        key_st_ff <= FCO_K_FAIL;
                    end
                end
                FCO_K_FAIL: key_st_ff <= FCO_K_FAIL;
                default: key_st_ff <= FCO_K_IDLE;
            endcase
        end
    end
    // ----------------------------------------
    // Status and command launch
    // ----------------------------------------
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            access_error_flag_ff <= 1'b0;
            blank_ff <= 1'b0;
        end else begin
            // Hardware set wins over a same-cycle software clear.
            if (pe_refused) begin
                access_error_flag_ff <= 1'b1;
            end else if (wr_status && i_wdata[FCO_ERR_BIT]) begin
                access_error_flag_ff <= 1'b0;
            end
            if (i_blank_done) begin
                blank_ff <= i_blank_ok;
            end else if (cmd_go) begin
                blank_ff <= 1'b0;
            end
        end
    end
    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            rdata_ff <= 8'h00;
            mem_rdata_ff <= 8'h00;
            mem_wr_en_ff <= 1'b0;
            cmd_start_ff <= 1'b0;
            cmd_code_ff <= 8'h00;
            remap_ff <= 1'b0;
            secure_ff <= 1'b1;
            o_nvm_timing_clock <= 1'b0;
        end else begin
            rdata_ff <= i_rd ? rd_mux : 8'h00;
            mem_rdata_ff <= mem_block ? 8'h00 : i_mem_rdata;
            mem_wr_en_ff <= i_mem_req && i_mem_wr && !mem_block;
            cmd_start_ff <= cmd_go;
            if (cmd_go) begin
                cmd_code_ff <= i_wdata;
            end
            remap_ff <= opts_ff[FCO_REMAP_OFF_BIT];
            secure_ff <= is_secure;
            o_nvm_timing_clock <= tk.tick;
        end
    end
    assign o_rdata = rdata_ff;
    assign o_mem_rdata = mem_rdata_ff;
    assign o_mem_wr_en = mem_wr_en_ff;
    assign o_cmd_start = cmd_start_ff;
    assign o_cmd_code = cmd_code_ff;
    assign o_vector_remap_off = remap_ff;
    assign o_secure = secure_ff;
    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_loaded_sticky;
        @(posedge i_mclk) disable iff (!i_resetn)
        ratio_loaded_flag_ff |=> ratio_loaded_flag_ff;
    endproperty
    a_loaded_sticky: assert property (p_loaded_sticky) else $error("loaded flag fell");
    property p_first_write;
        @(posedge i_mclk) disable iff (!i_resetn)
        (wr_ratio && !ratio_loaded_flag_ff) |=> ratio_loaded_flag_ff &&
            ratio_ff == $past(i_wdata[6:0]);
    endproperty
    a_first_write: assert property (p_first_write) else $error("first write lost");
    property p_once;
        @(posedge i_mclk) disable iff (!i_resetn)
        ratio_loaded_flag_ff |=> $stable(ratio_ff);
    endproperty
    a_once: assert property (p_once) else $error("ratio rewritten");
    property p_refuse;
        @(posedge i_mclk) disable iff (!i_resetn)
        (wr_cmd && is_pe && !ratio_loaded_flag_ff) |=> !o_cmd_start && access_error_flag_ff;
    endproperty
    a_refuse: assert property (p_refuse) else $error("early command ran");
    property p_no_tick;
        @(posedge i_mclk) disable iff (!i_resetn)
        !ratio_loaded_flag_ff |=> !tk.tick;
    endproperty
    a_no_tick: assert property (p_no_tick) else $error("tick before load");
    property p_tick_one;
        @(posedge i_mclk) disable iff (!i_resetn)
        (tk.tick && ratio_ff[5:0] != 6'h00) |=> !tk.tick;
    endproperty
    a_tick_one: assert property (p_tick_one) else $error("tick too long");
    property p_opts_hold;
        @(posedge i_mclk) disable iff (!i_resetn)
        opts_taken_ff |=> $stable(opts_ff);
    endproperty
    a_opts_hold: assert property (p_opts_hold) else $error("options changed");
    property p_block_rd;
        @(posedge i_mclk) disable iff (!i_resetn)
        (i_mem_req && is_secure && !i_secure_src) |=> o_mem_rdata == 8'h00 && !o_mem_wr_en;
    endproperty
    a_block_rd: assert property (p_block_rd) else $error("blocked access leaked");
    property p_nokey;
        @(posedge i_mclk) disable iff (!i_resetn)
        (!opts_ff[FCO_BACKDOOR_KEY_ALLOW_BIT] && !i_blank_done && is_secure) |=> is_secure;
    endproperty
    a_nokey: assert property (p_nokey) else $error("key bypass");
endmodule // fco_flash_opts
`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import fco_pkg::*;
    // ----------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------
    localparam logic [63:0] UNLOCK_KEY = 64'h0123_4567_89AB_CDEF;
    logic i_mclk = 1'b0;
    logic i_resetn = 1'b0;
    logic [3:0] i_addr = 4'h0;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic i_secure_src = 1'b1;
    logic i_mem_req = 1'b0;
    logic i_mem_wr = 1'b0;
    logic [7:0] i_mem_rdata = 8'h00;
    logic [7:0] i_stored_option_byte = 8'hFF;
    logic i_blank_done = 1'b0;
    logic i_blank_ok = 1'b0;
    logic [7:0] o_rdata, o_mem_rdata, o_cmd_code;
    logic o_mem_wr_en, o_nvm_timing_clock, o_cmd_start, o_vector_remap_off, o_secure;
    logic seen_start = 1'b0;
    logic [7:0] seen_code = 8'h00;
    logic [7:0] rd_val;
    int num_errors = 0;
    int total_checks = 0;
    int gap;

    always #10 i_mclk = ~i_mclk;

    fco_flash_opts dut_u (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_secure_src(i_secure_src),
        .i_mem_req(i_mem_req), .i_mem_wr(i_mem_wr), .i_mem_rdata(i_mem_rdata),
        .i_stored_option_byte(i_stored_option_byte), .i_stored_unlock_key(UNLOCK_KEY),
        .i_blank_done(i_blank_done), .i_blank_ok(i_blank_ok), .o_rdata(o_rdata),
        .o_mem_rdata(o_mem_rdata), .o_mem_wr_en(o_mem_wr_en),
        .o_nvm_timing_clock(o_nvm_timing_clock), .o_cmd_start(o_cmd_start),
        .o_cmd_code(o_cmd_code), .o_vector_remap_off(o_vector_remap_off),
        .o_secure(o_secure));

    // Command pulses last one cycle, so they are latched here and inspected later.
    always @(posedge i_mclk) begin
        if (o_cmd_start === 1'b1) begin
            seen_start <= 1'b1;
            seen_code <= o_cmd_code;
        end
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic do_reset(input logic [7:0] opt);
        @(posedge i_mclk);
        i_resetn <= 1'b0;
        i_stored_option_byte <= opt;
        repeat (12) @(posedge i_mclk);
        i_resetn <= 1'b1;
        // Level outputs are rebuilt from the reloaded options one edge after release.
        repeat (2) @(posedge i_mclk);
    endtask

    task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask

    task automatic bus_rd(input logic [3:0] a);
        @(posedge i_mclk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1 rd_val = o_rdata;
    endtask

    task automatic cmd(input logic [7:0] c, input logic exp_start);
        #1 seen_start = 1'b0;
        bus_wr(FCO_ADDR_CMD, c);
        repeat (4) @(posedge i_mclk);
        #1 chk({7'h00, seen_start}, {7'h00, exp_start});
        if (exp_start) chk(seen_code, c);
    endtask

    task automatic mem(input logic src, input logic wr, input logic [7:0] exp_rd,
                       input logic exp_wen);
        @(posedge i_mclk);
        i_mem_req <= 1'b1;
        i_mem_wr <= wr;
        i_secure_src <= src;
        i_mem_rdata <= 8'h5A;
        @(posedge i_mclk);
        i_mem_req <= 1'b0;
        i_secure_src <= 1'b1;
        #1 chk({7'h00, o_mem_wr_en}, {7'h00, exp_wen});
        if (!wr) chk(o_mem_rdata, exp_rd);
    endtask

    task automatic key_seq(input logic [63:0] k, input logic src);
        @(posedge i_mclk);
        i_secure_src <= src;
        bus_wr(FCO_ADDR_KEYCTL, 8'h20);
        for (int i = 0; i < FCO_KEY_BYTES; i++) begin
            bus_wr(FCO_ADDR_KEYDATA, k[8*i +: 8]);
        end
        bus_wr(FCO_ADDR_KEYCTL, 8'h00);
        i_secure_src <= 1'b1;
        repeat (4) @(posedge i_mclk);
    endtask

    task automatic stop_test;
        $display("checks=%0d errors=%0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        #400000;
        num_errors++;
        stop_test();
    end

    initial begin
        do_reset(8'hFF);
        bus_rd(FCO_ADDR_OPTS); chk(rd_val, 8'hC3);
        #1 chk({6'h00, o_secure, o_vector_remap_off}, 8'h03);
        bus_rd(FCO_ADDR_RATIO); chk(rd_val, 8'h00);
        cmd(FCO_CMD_PROG, 1'b0);
        bus_rd(FCO_ADDR_STATUS); chk(rd_val & 8'h10, 8'h10);
        bus_wr(FCO_ADDR_STATUS, 8'h10);
        bus_rd(FCO_ADDR_STATUS); chk(rd_val & 8'h10, 8'h00);
        bus_wr(FCO_ADDR_RATIO, 8'h60);
        bus_rd(FCO_ADDR_RATIO); chk(rd_val, 8'hE0);
        bus_wr(FCO_ADDR_RATIO, 8'h01);
        bus_rd(FCO_ADDR_RATIO); chk(rd_val, 8'hE0);
        bus_wr(FCO_ADDR_OPTS, 8'h00);
        bus_rd(FCO_ADDR_OPTS); chk(rd_val, 8'hC3);
        bus_rd(4'hF); chk(rd_val, 8'h00);
        // Prescale on and ratio 32 give one strobe every 8 * 33 bus cycles, about 189 kHz.
        gap = 0;
        while (o_nvm_timing_clock !== 1'b1 && gap < 300) begin
            @(posedge i_mclk); #1 gap++;
        end
        @(posedge i_mclk); #1 chk({7'h00, o_nvm_timing_clock}, 8'h00);
        gap = 1;
        while (o_nvm_timing_clock !== 1'b1 && gap < 300) begin
            @(posedge i_mclk); #1 gap++;
        end
        chk(gap[15:0], 16'h0108);
        cmd(FCO_CMD_PROG, 1'b1);
        cmd(FCO_CMD_BURST, 1'b1);
        cmd(FCO_CMD_PAGE_ERASE, 1'b1);
        cmd(FCO_CMD_MASS_ERASE, 1'b1);
        mem(1'b0, 1'b0, 8'h00, 1'b0);
        mem(1'b0, 1'b1, 8'h00, 1'b0);
        mem(1'b1, 1'b0, 8'h5A, 1'b0);
        mem(1'b1, 1'b1, 8'h00, 1'b1);
        key_seq(UNLOCK_KEY ^ 64'h0100, 1'b1);
        #1 chk({7'h00, o_secure}, 8'h01);
        key_seq(UNLOCK_KEY, 1'b0);
        #1 chk({7'h00, o_secure}, 8'h01);
        key_seq(UNLOCK_KEY, 1'b1);
        #1 chk({7'h00, o_secure}, 8'h00);
        bus_rd(FCO_ADDR_OPTS); chk(rd_val, 8'hC2);
        mem(1'b0, 1'b0, 8'h5A, 1'b0);
        // A fresh reset must relock and forget the loaded ratio.
        do_reset(8'h7F);
        #1 chk({6'h00, o_secure, o_vector_remap_off}, 8'h03);
        bus_rd(FCO_ADDR_RATIO); chk(rd_val, 8'h00);
        key_seq(UNLOCK_KEY, 1'b1);
        #1 chk({7'h00, o_secure}, 8'h01);
        // Every code other than 1:0 keeps the part locked.
        for (int c = 0; c < 4; c++) begin
            do_reset({6'h20, c[1:0]});
            #1 chk({o_secure, o_vector_remap_off}, {c[1:0] != 2'h2, 1'b0});
        end
        do_reset(8'h03);
        bus_wr(FCO_ADDR_RATIO, 8'h60);
        cmd(FCO_CMD_BLANK, 1'b1);
        @(posedge i_mclk);
        i_blank_done <= 1'b1;
        i_blank_ok <= 1'b1;
        @(posedge i_mclk);
        i_blank_done <= 1'b0;
        i_blank_ok <= 1'b0;
        repeat (3) @(posedge i_mclk);
        #1 chk({7'h00, o_secure}, 8'h00);
        bus_rd(FCO_ADDR_OPTS); chk(rd_val, 8'h02);
        bus_rd(FCO_ADDR_STATUS); chk(rd_val & 8'h04, 8'h04);
        stop_test();
    end
endmodule // tb_top
`default_nettype wire
